// ---- pkg/qdm_pkg.sv ----
// qdm_pkg: types and constants for the decoder 1 phase pin multiplexer.
// assumes a single core clock domain and active low asynchronous reset.
`default_nettype none

package qdm_pkg;

   // pin slots
   localparam int unsigned NUM_PINS      = 2;
   localparam int unsigned PIN_PHASE_A   = 0;
   localparam int unsigned PIN_PHASE_B   = 1;

   // port c pull-up enable bit positions
   localparam int unsigned PUR_BIT_PHASE_A = 0;
   localparam int unsigned PUR_BIT_PHASE_B = 1;

   // reset values
   localparam logic [1:0] PUR_RESET      = 2'h3;
   localparam logic       PAD_OUT_RESET  = 1'h0;
   localparam logic       PAD_OE_RESET   = 1'h0;
   localparam logic       PULLUP_RESET   = 1'h1;
   localparam logic       CORE_IN_RESET  = 1'h0;
   localparam logic       DEC_IDLE       = 1'h0;

   // pin functions, gray along decoder, timer, gpio, spi
   typedef enum logic [2:0] {
      FUNC_DECODER = 3'h0,
      FUNC_TIMER   = 3'h1,
      FUNC_GPIO    = 3'h3,
      FUNC_SPI     = 3'h2,
      FUNC_NONE    = 3'h6
   } qdm_func_t;

   // per pin request toward the pad slice
   typedef struct packed {
      qdm_func_t func;
      logic      alt_sel;
      logic      spi_ctrl_mode;
      logic      spi_out;
      logic      timer_out;
      logic      timer_oe;
      logic      gpio_dir_out;
      logic      gpio_out;
      logic      pullup_bit;
      logic      pad_in;
   } qdm_pin_req_t;

   // per pin pad and core-side result
   typedef struct packed {
      logic pad_out;
      logic pad_oe;
      logic pullup_on;
      logic dec_in;
      logic timer_in;
      logic spi_in;
      logic gpio_in;
      logic spi_active;
   } qdm_pin_resp_t;

   localparam qdm_pin_resp_t PIN_RESP_RESET = '{
      pad_out:    PAD_OUT_RESET,
      pad_oe:     PAD_OE_RESET,
      pullup_on:  PULLUP_RESET,
      dec_in:     DEC_IDLE,
      timer_in:   CORE_IN_RESET,
      spi_in:     CORE_IN_RESET,
      gpio_in:    CORE_IN_RESET,
      spi_active: 1'h0
   };

endpackage : qdm_pkg

`default_nettype wire

// ---- core/qdm_pin_slice.sv ----
// qdm_pin_slice: combinational function mux for one multiplexed pin.
// assumes the caller registers every result and feeds synchronous pad input.
`default_nettype none

module qdm_pin_slice (
   input  wire  qdm_pkg::qdm_pin_req_t  req,
   output var   qdm_pkg::qdm_pin_resp_t resp
);
   import qdm_pkg::*;

   always_comb begin
      resp            = '0;
      resp.dec_in     = DEC_IDLE;
      case (req.func)
         FUNC_DECODER: begin
            resp.dec_in = req.pad_in;
         end
         FUNC_TIMER: begin
            resp.pad_out  = req.timer_out;
            resp.pad_oe   = req.timer_oe;
            resp.timer_in = req.pad_in;
         end
         FUNC_SPI: begin
            if (req.alt_sel) begin
               resp.spi_active = 1'b1;
               if (req.spi_ctrl_mode) begin
                  resp.pad_out = req.spi_out;
                  resp.pad_oe  = 1'b1;
               end else begin
                  resp.spi_in = req.pad_in;
               end
            end
         end
         FUNC_GPIO: begin
            resp.pad_out = req.gpio_out;
            resp.pad_oe  = req.gpio_dir_out;
            resp.gpio_in = req.pad_in;
         end
         default: begin
            resp.pad_oe = 1'b0;
         end
      endcase
      resp.pullup_on = req.pullup_bit & ~resp.pad_oe;
   end

endmodule : qdm_pin_slice

`default_nettype wire

// ---- core/qdm_pin_mux.sv ----
// qdm_pin_mux: function select and pad control for decoder 1 phase a/b pins.
// assumes all inputs synchronous to core_clk; pads resolved outside from out/oe.
`default_nettype none

// Operation
// - first pin carries decoder phase a, timer b ch0, spi clock or port c line 0
// - second pin carries decoder phase b, timer b ch1, spi data out or port c line 1
// - spi clock reaches first pin only while phase a alt select is set
// - spi data out reaches second pin only while phase b alt select is set
// - full variant comes out of reset with phase a decoder on pin one
// - full variant comes out of reset with phase b decoder on pin two
// - clearing pull-up enable bit 0 turns off first pin pull-up
// - clearing pull-up enable bit 1 turns off second pin pull-up
// - spi clock pin drives in controller mode, receives in peripheral mode
// - controller drives data out, peripheral samples; half-cycle lead kept
// - port c pins have independently programmable direction
module qdm_pin_mux #(
   parameter bit FULL_VARIANT = 1'b1
) (
   input  wire  logic                    core_clk,
   input  wire  logic                    rst_n,
   // function select writes
   input  wire  logic [1:0]              func_wr_en,
   input  wire  qdm_pkg::qdm_func_t      func_wr_val_a,
   input  wire  qdm_pkg::qdm_func_t      func_wr_val_b,
   // system peripheral select bits
   input  wire  logic                    phase_a_alt_select,
   input  wire  logic                    phase_b_alt_select,
   // port c pull-up enable bits
   input  wire  logic [1:0]              port_c_pullup_enable_reg,
   // port c direction and data
   input  wire  logic [1:0]              port_c_dir_out,
   input  wire  logic [1:0]              port_c_data_out,
   // timer b channels 0 and 1
   input  wire  logic [1:0]              timer_b_out,
   input  wire  logic [1:0]              timer_b_oe,
   // spi port 1 engine side
   input  wire  logic                    spi_ctrl_mode,
   input  wire  logic                    spi_port1_clock_out,
   input  wire  logic                    spi_port1_ctrl_out,
   // pads
   input  wire  logic [1:0]              pad_in,
   output logic [1:0]                    pad_out,
   output logic [1:0]                    pad_oe,
   output logic [1:0]                    pad_pullup_en,
   // core side inputs
   output logic                          decoder1_phase_a_in,
   output logic                          decoder1_phase_b_in,
   output logic                          timer_b_channel_0,
   output logic                          timer_b_channel_1,
   output logic                          spi_port1_clock_in,
   output logic                          spi_port1_ctrl_out_in,
   output logic [1:0]                    port_c_line_in,
   // status
   output var qdm_pkg::qdm_func_t        func_state_a,
   output var qdm_pkg::qdm_func_t        func_state_b,
   output logic [1:0]                    spi_route_active,
   output logic [1:0]                    pin_unconfigured
);
   import qdm_pkg::*;

   localparam qdm_func_t FUNC_RESET = FULL_VARIANT ? FUNC_DECODER : FUNC_NONE;

   typedef struct packed {
      qdm_func_t [NUM_PINS-1:0]     func;
      qdm_pin_resp_t [NUM_PINS-1:0] pin;
      logic [NUM_PINS-1:0]          unconf;
   } qdm_state_t;

   localparam qdm_state_t STATE_RESET = '{
      func:   '{FUNC_RESET, FUNC_RESET},
      pin:    '{PIN_RESP_RESET, PIN_RESP_RESET},
      unconf: FULL_VARIANT ? 2'h0 : 2'h3
   };

   qdm_state_t                   st_q;
   qdm_state_t                   st_d;
   qdm_pin_req_t [NUM_PINS-1:0]  req;
   qdm_pin_resp_t [NUM_PINS-1:0] resp;
   qdm_func_t [NUM_PINS-1:0]     wr_val;
   logic [NUM_PINS-1:0]          alt_sel;
   logic [NUM_PINS-1:0]          spi_src;

   assign wr_val[PIN_PHASE_A]  = func_wr_val_a;
   assign wr_val[PIN_PHASE_B]  = func_wr_val_b;
   assign alt_sel[PIN_PHASE_A] = phase_a_alt_select;
   assign alt_sel[PIN_PHASE_B] = phase_b_alt_select;
   assign spi_src[PIN_PHASE_A] = spi_port1_clock_out;
   // spi data out on second pin
   assign spi_src[PIN_PHASE_B] = spi_port1_ctrl_out;

   function automatic logic func_legal(input qdm_func_t f);
      logic ok;
      ok = 1'b0;
      case (f)
         FUNC_DECODER: ok = 1'b1;
         FUNC_TIMER:   ok = 1'b1;
         FUNC_SPI:     ok = 1'b1;
         FUNC_GPIO:    ok = 1'b1;
         default:      ok = 1'b0;
      endcase
      return ok;
   endfunction : func_legal

   genvar gi;
   generate
      for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
         always_comb begin
            req[gi].func          = st_q.func[gi];
            req[gi].alt_sel       = alt_sel[gi];
            req[gi].spi_ctrl_mode = spi_ctrl_mode;
            req[gi].spi_out       = spi_src[gi];
            req[gi].timer_out     = timer_b_out[gi];
            req[gi].timer_oe      = timer_b_oe[gi];
            req[gi].gpio_dir_out  = port_c_dir_out[gi];
            req[gi].gpio_out      = port_c_data_out[gi];
            req[gi].pullup_bit    = port_c_pullup_enable_reg[gi];
            req[gi].pad_in        = pad_in[gi];
         end

         qdm_pin_slice u_slice (
            .req  (req[gi]),
            .resp (resp[gi])
         );
      end
   endgenerate

   always_comb begin
      st_d     = st_q;
      st_d.pin = resp;
      for (int i = 0; i < NUM_PINS; i++) begin
         // illegal encodings leave the selection unchanged
         if (func_wr_en[i] && func_legal(wr_val[i])) begin
            st_d.func[i]   = wr_val[i];
            // cleared once software programs a function
            st_d.unconf[i] = 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= STATE_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   // clock and data share one register stage, keeping the half-cycle lead
   always_comb begin
      for (int i = 0; i < NUM_PINS; i++) begin
         pad_out[i]          = st_q.pin[i].pad_out;
         pad_oe[i]           = st_q.pin[i].pad_oe;
         pad_pullup_en[i]    = st_q.pin[i].pullup_on;
         port_c_line_in[i]   = st_q.pin[i].gpio_in;
         spi_route_active[i] = st_q.pin[i].spi_active;
      end
   end

   assign decoder1_phase_a_in   = st_q.pin[PIN_PHASE_A].dec_in;
   assign decoder1_phase_b_in   = st_q.pin[PIN_PHASE_B].dec_in;
   assign timer_b_channel_0     = st_q.pin[PIN_PHASE_A].timer_in;
   assign timer_b_channel_1     = st_q.pin[PIN_PHASE_B].timer_in;
   assign spi_port1_clock_in    = st_q.pin[PIN_PHASE_A].spi_in;
   assign spi_port1_ctrl_out_in = st_q.pin[PIN_PHASE_B].spi_in;
   assign func_state_a          = st_q.func[PIN_PHASE_A];
   assign func_state_b          = st_q.func[PIN_PHASE_B];
   assign pin_unconfigured      = st_q.unconf;

endmodule : qdm_pin_mux

`default_nettype wire

// ---- tb/qdm_pin_mux_sva.sv ----
// qdm_pin_mux_sva: port checks for the pin mux.
// assumes bind onto qdm_pin_mux, one clock.
`default_nettype none
module qdm_pin_mux_sva #(parameter bit FULL_VARIANT = 1'b1) (
   input wire logic               core_clk,
   input wire logic               rst_n,
   input wire logic               phase_a_alt_select,
   input wire logic               phase_b_alt_select,
   input wire logic [1:0]         port_c_pullup_enable_reg,
   input wire logic [1:0]         port_c_dir_out,
   input wire logic               spi_ctrl_mode,
   input wire logic               spi_port1_ctrl_out,
   input wire logic [1:0]         pad_out,
   input wire logic [1:0]         pad_oe,
   input wire logic [1:0]         pad_pullup_en,
   input wire qdm_pkg::qdm_func_t func_state_a,
   input wire qdm_pkg::qdm_func_t func_state_b
);
   import qdm_pkg::*;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   localparam qdm_func_t DFLT = FULL_VARIANT ? FUNC_DECODER : FUNC_NONE;
   wire sa = func_state_a == FUNC_SPI;
   wire sb = func_state_b == FUNC_SPI;
   AST_RST_DEF: assert property (disable iff (1'b0)
      !rst_n |=> func_state_a == DFLT && func_state_b == DFLT) else $error("reset func");
   AST_SCK_GATE: assert property (sa && !phase_a_alt_select |=> !pad_oe[0])
      else $error("sck gate");
   AST_MOSI_GATE: assert property (sb && !phase_b_alt_select |=> !pad_oe[1])
      else $error("mosi gate");
   AST_SCK_DIR: assert property (sa && phase_a_alt_select |=> pad_oe[0] == $past(spi_ctrl_mode))
      else $error("sck dir");
   AST_MOSI_OUT: assert property (sb && phase_b_alt_select && spi_ctrl_mode
      |=> pad_oe[1] && pad_out[1] == $past(spi_port1_ctrl_out)) else $error("mosi out");
   AST_PU_A: assert property (!port_c_pullup_enable_reg[0] |=> !pad_pullup_en[0])
      else $error("pullup a");
   AST_PU_B: assert property (!port_c_pullup_enable_reg[1] |=> !pad_pullup_en[1])
      else $error("pullup b");
   AST_GPIO_DIR: assert property (func_state_b == FUNC_GPIO
      |=> pad_oe[1] == $past(port_c_dir_out[1])) else $error("gpio dir");
   cover property (sa && phase_a_alt_select && spi_ctrl_mode);
   cover property (sb && !phase_b_alt_select);
   cover property (func_state_b == FUNC_GPIO && port_c_dir_out[1]);
endmodule : qdm_pin_mux_sva
bind qdm_pin_mux qdm_pin_mux_sva #(.FULL_VARIANT(FULL_VARIANT)) qdm_pin_mux_sva_i (.*);
`default_nettype wire

// ---- tb/qdm_pad_model.sv ----
// qdm_pad_model: board side of the two pins.
// assumes ext drive only matters while pins float.
`default_nettype none
module qdm_pad_model (
   input wire logic       core_clk,
   input wire logic [1:0] pad_out,
   input wire logic [1:0] pad_oe,
   input wire logic [1:0] pad_pullup_en,
   input wire logic [1:0] ext_oe,
   input wire logic [1:0] ext_val,
   output var logic [1:0] pad_in
);
   logic [1:0] churn_q = 2'h1;
   always @(posedge core_clk) churn_q <= ~churn_q;
   always_comb begin
      pad_in = churn_q;
      for (int i = 0; i < 2; i++) begin
         if (pad_oe[i]) pad_in[i] = pad_out[i];
         else if (ext_oe[i]) pad_in[i] = ext_val[i];
         else if (pad_pullup_en[i]) pad_in[i] = 1'h1;
      end
   end
endmodule : qdm_pad_model
`default_nettype wire

// ---- tb/qdm_pin_mux_test.sv ----
// qdm_pin_mux_test: directed and random checks of the pin mux.
// assumes the pad model resolves both pins.
`default_nettype none
module qdm_pin_mux_test;
   timeunit 1ns;
   timeprecision 1ns;
   import qdm_pkg::*;
   logic       core_clk, rst_n, phase_a_alt_select, phase_b_alt_select, spi_ctrl_mode;
   logic       spi_port1_clock_out, spi_port1_ctrl_out, decoder1_phase_a_in, decoder1_phase_b_in;
   logic       timer_b_channel_0, timer_b_channel_1, spi_port1_clock_in, spi_port1_ctrl_out_in;
   logic [1:0] func_wr_en, port_c_pullup_enable_reg, port_c_dir_out, port_c_data_out, timer_b_out;
   logic [1:0] timer_b_oe, pad_in, pad_out, pad_oe, pad_pullup_en, port_c_line_in, ext_oe, ext_val;
   logic [1:0] spi_route_active, pin_unconfigured, pin_s;
   qdm_func_t  func_wr_val_a, func_wr_val_b, func_state_a, func_state_b, s_a, s_b;
   qdm_func_t  r_func_a, r_func_b;
   logic [1:0] r_unconf;
   int         bad_count = 0, compares = 0, cycles = 0;
   qdm_pin_mux #(.FULL_VARIANT(1'b1)) qdm_pin_mux_i (.*);
   // reduced variant: shares every input, only its selection state and unconfigured flags are watched
   qdm_pin_mux #(.FULL_VARIANT(1'b0)) qdm_pin_mux_red_i (.*, .pad_out(), .pad_oe(),
      .pad_pullup_en(), .decoder1_phase_a_in(), .decoder1_phase_b_in(), .timer_b_channel_0(),
      .timer_b_channel_1(), .spi_port1_clock_in(), .spi_port1_ctrl_out_in(), .port_c_line_in(),
      .spi_route_active(), .func_state_a(r_func_a), .func_state_b(r_func_b),
      .pin_unconfigured(r_unconf));
   qdm_pad_model qdm_pad_model_i (.*);
   always #5 core_clk = ~core_clk;
   always @(negedge core_clk) pin_s = pad_in;
   always @(posedge core_clk) begin
      cycles++;
      if (cycles > 5000) begin
         bad_count++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : wrap_up
   task automatic check_pin(input string what, input logic [6:0] exp, input logic [6:0] got);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s exp %h got %h", what, exp, got);
      end
   endtask : check_pin
   task automatic check_func(input string what, input qdm_func_t exp, input qdm_func_t got);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s exp %h got %h", what, exp, got);
      end
   endtask : check_func
   task automatic check_red(input qdm_func_t f, input logic [1:0] u);
      check_func("red state a", f, r_func_a);
      check_func("red state b", f, r_func_b);
      check_pin("red unconf", {5'h00, u}, {5'h00, r_unconf});
   endtask : check_red
   // {oe, out, pullup, decoder, timer, spi, gpio} seen one cycle on
   function automatic logic [6:0] exp_pin(input int i, input qdm_func_t f);
      logic alt, oe, out;
      alt = i ? phase_b_alt_select : phase_a_alt_select;
      {oe, out} = 2'h0;
      if (f == FUNC_TIMER) {oe, out} = {timer_b_oe[i], timer_b_out[i]};
      if (f == FUNC_GPIO) {oe, out} = {port_c_dir_out[i], port_c_data_out[i]};
      if (f == FUNC_SPI && alt && spi_ctrl_mode) oe = 1'h1;
      if (f == FUNC_SPI && alt && spi_ctrl_mode) out = i ? spi_port1_ctrl_out : spi_port1_clock_out;
      return {oe, out & oe, port_c_pullup_enable_reg[i] & ~oe, pin_s[i] & (f == FUNC_DECODER),
              pin_s[i] & (f == FUNC_TIMER), pin_s[i] & (f == FUNC_SPI) & alt & ~spi_ctrl_mode,
              pin_s[i] & (f == FUNC_GPIO)};
   endfunction : exp_pin
   task automatic step();
      @(posedge core_clk);
      #1;
      check_pin("pin a", exp_pin(0, s_a), {pad_oe[0], pad_out[0] & pad_oe[0], pad_pullup_en[0],
         decoder1_phase_a_in, timer_b_channel_0, spi_port1_clock_in, port_c_line_in[0]});
      check_pin("pin b", exp_pin(1, s_b), {pad_oe[1], pad_out[1] & pad_oe[1], pad_pullup_en[1],
         decoder1_phase_b_in, timer_b_channel_1, spi_port1_ctrl_out_in, port_c_line_in[1]});
      check_pin("route", {5'h00, s_b == FUNC_SPI && phase_b_alt_select,
         s_a == FUNC_SPI && phase_a_alt_select}, {5'h00, spi_route_active});
      check_pin("unconf", 7'h00, {5'h00, pin_unconfigured});
      if (func_wr_en[0] && func_wr_val_a <= FUNC_GPIO) s_a = func_wr_val_a;
      if (func_wr_en[1] && func_wr_val_b <= FUNC_GPIO) s_b = func_wr_val_b;
      check_func("state a", s_a, func_state_a);
      check_func("state b", s_b, func_state_b);
   endtask : step
   task automatic run(input int n);
      repeat (n) begin
         {func_wr_en, phase_a_alt_select, phase_b_alt_select, port_c_pullup_enable_reg,
          port_c_dir_out, port_c_data_out, timer_b_out, timer_b_oe, spi_ctrl_mode,
          spi_port1_clock_out, spi_port1_ctrl_out, ext_oe, ext_val} = 21'($urandom);
         func_wr_val_a = qdm_func_t'($urandom_range(7));
         func_wr_val_b = qdm_func_t'($urandom_range(7));
         step();
      end
   endtask : run
   initial begin
      core_clk = 1'h0;
      rst_n = 1'h0;
      {phase_a_alt_select, phase_b_alt_select, spi_ctrl_mode, spi_port1_clock_out} = 4'h0;
      {spi_port1_ctrl_out, func_wr_en, port_c_dir_out, port_c_data_out} = 7'h00;
      {timer_b_out, timer_b_oe, ext_oe, ext_val} = 8'h00;
      port_c_pullup_enable_reg = 2'h3;
      func_wr_val_a = FUNC_DECODER;
      func_wr_val_b = FUNC_DECODER;
      s_a = FUNC_DECODER;
      s_b = FUNC_DECODER;
      void'($urandom(2));
      repeat (2) @(posedge core_clk);
      #1;
      check_func("reset a", FUNC_DECODER, func_state_a);
      check_func("reset b", FUNC_DECODER, func_state_b);
      check_red(FUNC_NONE, 2'h3);
      rst_n = 1'h1;
      // refused code, then spi with alt off and on
      func_wr_en = 2'h3;
      func_wr_val_a = FUNC_NONE;
      func_wr_val_b = FUNC_NONE;
      step();
      check_red(FUNC_NONE, 2'h3);
      // software selects a function before use
      func_wr_val_a = FUNC_SPI;
      func_wr_val_b = FUNC_SPI;
      spi_ctrl_mode = 1'h1;
      step();
      check_red(FUNC_SPI, 2'h0);
      func_wr_en = 2'h0;
      step();
      {phase_a_alt_select, phase_b_alt_select, spi_port1_ctrl_out} = 3'h7;
      repeat (2) step();
      run(1500);
      rst_n = 1'h0;
      @(posedge core_clk);
      #1;
      check_func("mid reset", FUNC_DECODER, func_state_a);
      check_red(FUNC_NONE, 2'h3);
      s_a = FUNC_DECODER;
      s_b = FUNC_DECODER;
      rst_n = 1'h1;
      run(1500);
      wrap_up();
   end
endmodule : qdm_pin_mux_test
`default_nettype wire
